// [core/pgm_map_consts.vh]
// Constants for the program-space address mapper.
// Assumes a 16-bit data path and a 24-bit program address bus.
// Notes on behaviour
// - Program addresses are 24 bits wide; table and visibility addresses are built from 16-bit data-side values plus a page register.
// - Table reads and writes reach any byte or word of program space, all three bytes of a word included.
// - Visibility accesses are read-only and return only the low word of the program word.
// - A table address is the 8-bit table page in the top bits over the full 16-bit effective address.
// - Each table page value selects a 32K-word region.
// - Table page bit 7 picks user memory when 0 and configuration memory when 1.
// - A data-access effective address with bit 15 set is remapped as visibility page over the low 15 address bits.
// - A remapped access always drives program address bit 23 low.
// - In a remap, address bit 15 is ignored and program bit 15 comes from visibility page bit 0.
// - Instruction fetch forces bits 23 and 0 low and takes bits 22 to 1 from the program counter.
`ifndef PGM_MAP_CONSTS_VH
`define PGM_MAP_CONSTS_VH

`define PA_W        24
`define DA_W        16
`define PAGE_W      8
`define BYTE_W      8
`define PAGE_RST    8'h00
`define CFG_BIT     7
`define REMAP_BIT   15
`define OP_IDLE     2'h0
`define OP_FETCH    2'h1
`define OP_TBL_RD   2'h2
`define OP_TBL_WT   2'h3

`endif

// [core/pgm_space_mapper.v]
// Program-space address mapper between the core address generator and flash.
// Assumes one request per cycle from the core and flash read data one cycle later.
`timescale 1ns/1ps
`include "pgm_map_consts.vh"

module pgm_space_mapper
(
   // Clock and reset
   input  wire                 clock,
   input  wire                 nrst,
   // Page register writes
   input  wire                 table_page_we,
   input  wire                 visibility_page_we,
   input  wire [`PAGE_W-1:0]   page_wdata,
   // Core request
   input  wire [1:0]           op_sel,
   input  wire                 data_rd,
   input  wire                 data_wr,
   input  wire                 byte_mode,
   input  wire                 high_byte,
   input  wire [`DA_W-1:0]     effective_address,
   input  wire [`DA_W-1:0]     wdata,
   input  wire [`PA_W-1:1]     pc,
   // Flash read data
   input  wire [`PA_W-1:0]     flash_rdata,
   // Flash side
   output reg  [`PA_W-1:0]     prog_addr_ff,
   output reg                  prog_rd_ff,
   output reg                  prog_wr_ff,
   output reg                  cfg_space_ff,
   output reg  [`DA_W-1:0]     prog_wdata_ff,
   output reg  [2:0]           prog_byte_en_ff,
   // Data memory side
   output reg  [`DA_W-1:0]     dmem_addr_ff,
   output reg                  dmem_rd_ff,
   output reg                  dmem_wr_ff,
   // Core read return
   output reg  [`DA_W-1:0]     rdata_ff,
   output reg                  rvalid_ff,
   // Page register views
   output reg  [`PAGE_W-1:0]   table_page_reg,
   output reg  [`PAGE_W-1:0]   visibility_page_reg
);

   ////////////////////////////////////////////////////////////////////
   // Decode helpers
   function is_remap;
      input [`DA_W-1:0] ea;
      begin
         is_remap = ea[`REMAP_BIT];
      end
   endfunction

   function [`PA_W-1:0] psv_addr;
      input [`PAGE_W-1:0] pg;
      input [`DA_W-1:0]   ea;
      begin
         psv_addr = {1'b0, pg[`PAGE_W-1:1], pg[0], ea[14:0]};
      end
   endfunction

   reg  [`PA_W-1:0]   nxt_addr;
   reg                nxt_prd;
   reg                nxt_pwr;
   reg                nxt_drd;
   reg                nxt_dwr;
   reg  [2:0]         nxt_ben;
   reg  [`PA_W-1:0]   nxt_word;
   reg                rd_pend_ff;
   reg                rd_psv_ff;
   reg                rd_byte_ff;
   reg  [1:0]         rd_lane_ff;
   wire [`PA_W-1:0]   word_ff;
   wire               is_tbl;
   wire               remap;

   assign is_tbl = (op_sel == `OP_TBL_RD) || (op_sel == `OP_TBL_WT);
   assign remap  = (op_sel == `OP_IDLE) && is_remap(effective_address);

   ////////////////////////////////////////////////////////////////////
   // Page registers
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         table_page_reg      <= `PAGE_RST;
         visibility_page_reg <= `PAGE_RST;
      end
      else
      begin
         if (table_page_we)
            table_page_reg <= page_wdata;
         if (visibility_page_we)
            visibility_page_reg <= page_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address construction
   always @*
   begin
      nxt_addr = 24'h000000;
      nxt_prd  = 1'b0;
      nxt_pwr  = 1'b0;
      nxt_drd  = 1'b0;
      nxt_dwr  = 1'b0;
      nxt_ben  = 3'h0;
      case (op_sel)
         `OP_FETCH:
         begin
            nxt_addr = {1'b0, pc[22:1], 1'b0};
            nxt_prd  = 1'b1;
            nxt_ben  = 3'h7;
         end
         `OP_TBL_RD,
         `OP_TBL_WT:
         begin
            nxt_addr = {table_page_reg, effective_address};
            nxt_prd  = (op_sel == `OP_TBL_RD);
            nxt_pwr  = (op_sel == `OP_TBL_WT);
            // Byte lanes: word op covers low word, high byte op reaches upper byte
            if (!byte_mode)
               nxt_ben = 3'h3;
            else if (high_byte)
               nxt_ben = 3'h4;
            else if (effective_address[0])
               nxt_ben = 3'h2;
            else
               nxt_ben = 3'h1;
         end
         `OP_IDLE:
         begin
            if (remap)
            begin
               nxt_addr = psv_addr(visibility_page_reg, effective_address);
               nxt_prd  = data_rd;                      // writes dropped
               nxt_ben  = data_rd ? 3'h3 : 3'h0;
            end
            else
            begin
               nxt_drd = data_rd;
               nxt_dwr = data_wr;
            end
         end
         default:
         begin
            nxt_addr = 24'h000000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Request registers
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         prog_addr_ff    <= 24'h000000;
         prog_rd_ff      <= 1'b0;
         prog_wr_ff      <= 1'b0;
         cfg_space_ff    <= 1'b0;
         prog_wdata_ff   <= 16'h0000;
         prog_byte_en_ff <= 3'h0;
         dmem_addr_ff    <= 16'h0000;
         dmem_rd_ff      <= 1'b0;
         dmem_wr_ff      <= 1'b0;
         rd_pend_ff      <= 1'b0;
         rd_psv_ff       <= 1'b0;
         rd_byte_ff      <= 1'b0;
         rd_lane_ff      <= 2'h0;
      end
      else
      begin
         prog_addr_ff    <= nxt_addr;
         prog_rd_ff      <= nxt_prd;
         prog_wr_ff      <= nxt_pwr;
         cfg_space_ff    <= is_tbl & table_page_reg[`CFG_BIT];
         prog_wdata_ff   <= wdata;
         prog_byte_en_ff <= nxt_ben;
         dmem_addr_ff    <= effective_address;
         dmem_rd_ff      <= nxt_drd;
         dmem_wr_ff      <= nxt_dwr;
         rd_pend_ff      <= nxt_prd && (op_sel != `OP_FETCH);
         rd_psv_ff       <= remap;
         rd_byte_ff      <= byte_mode;
         rd_lane_ff      <= high_byte ? 2'h2 : {1'b0, effective_address[0]};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Flash word capture
   pgm_word_reg u_word
   (
      .clock   (clock),
      .nrst    (nrst),
      .load    (rd_pend_ff),
      .word_in (nxt_word),
      .word_ff (word_ff)
   );

   ////////////////////////////////////////////////////////////////////
   // Lane steering ahead of the word register, zero-extended
   always @*
   begin
      nxt_word = 24'h000000;
      if (rd_psv_ff || !rd_byte_ff)
         nxt_word = {8'h00, flash_rdata[15:0]};
      else if (rd_lane_ff == 2'h2)
         nxt_word = {16'h0000, flash_rdata[23:16]};
      else if (rd_lane_ff == 2'h1)
         nxt_word = {16'h0000, flash_rdata[15:8]};
      else
         nxt_word = {16'h0000, flash_rdata[7:0]};
   end

   // Read data is the low word of the captured register
   always @*
   begin
      rdata_ff = word_ff[`DA_W-1:0];
   end

   // Read valid pulse, one cycle behind the flash request
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         rvalid_ff <= 1'b0;
      else
         rvalid_ff <= rd_pend_ff;
   end

endmodule // pgm_space_mapper

// [core/pgm_word_reg.v]
// Output register for one 24-bit program word with load enable.
// Assumes the flash word arrives on the same clock as the request.
`timescale 1ns/1ps
`include "pgm_map_consts.vh"

module pgm_word_reg
(
   // Clock and reset
   input  wire                 clock,
   input  wire                 nrst,
   // Capture
   input  wire                 load,
   input  wire [`PA_W-1:0]     word_in,
   // Stored word
   output reg  [`PA_W-1:0]     word_ff
);

   ////////////////////////////////////////////////////////////////////
   // Capture register
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         word_ff <= 24'h000000;
      else if (load)
         word_ff <= word_in;
   end

endmodule // pgm_word_reg

// [tb/flash_model.sv]
// Program flash model answering the mapper's reads.
// Word follows the address; a released bus shows it inverted.
`timescale 1ns/1ps
module flash_model
(
   // Request
   input  wire        prog_rd_ff,
   input  wire [23:0] prog_addr_ff,
   // Read word
   output wire [23:0] flash_rdata
);
   // Address-derived word, inverted outside reads
   assign flash_rdata = prog_addr_ff ^ 24'h3CA5C3 ^ {24{!prog_rd_ff}};
endmodule // flash_model

// [tb/pgm_map_chk.sv]
// Concurrent checks on the program-space mapper ports.
// Bound to every pgm_space_mapper; one clock, async low reset.
`timescale 1ns/1ps
module pgm_map_chk
(
   // Clock, reset and core request
   input wire        clock, nrst, data_rd, data_wr,
   input wire [1:0]  op_sel,
   input wire [15:0] effective_address, wdata,
   input wire [23:1] pc,
   input wire [7:0]  table_page_reg, visibility_page_reg,
   // Memory side and read return
   input wire        prog_rd_ff, prog_wr_ff, cfg_space_ff, dmem_rd_ff, dmem_wr_ff, rvalid_ff,
   input wire [23:0] prog_addr_ff,
   input wire [15:0] prog_wdata_ff, dmem_addr_ff
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // Data access into the upper half of data space
   wire rmp = op_sel == 2'h0 && effective_address[15];
   ////////////////////////////////////////////////////////////////////////////////
   AST_TBL_ADDR: assert property (op_sel[1] |=> prog_addr_ff ==
      {$past(table_page_reg), $past(effective_address)}) else $error("table address wrong");
   AST_TBL_CFG: assert property (op_sel[1] |=> cfg_space_ff == $past(table_page_reg[7]))
      else $error("config select wrong");
   AST_TBL_RD: assert property (op_sel == 2'h2 |=> prog_rd_ff ##1 rvalid_ff) else $error("table read lost");
   AST_TBL_WT: assert property (op_sel == 2'h3 |=> prog_wr_ff && prog_wdata_ff == $past(wdata))
      else $error("table write lost");
   AST_REMAP: assert property (rmp && data_rd |=> prog_rd_ff && prog_addr_ff ==
      {1'b0, $past(visibility_page_reg), $past(effective_address[14:0])}) else $error("remap address wrong");
   AST_REMAP_WR: assert property (rmp && data_wr |=> !prog_wr_ff && !dmem_wr_ff) else $error("remap write done");
   AST_FETCH: assert property (op_sel == 2'h1 |=> prog_addr_ff == {1'b0, $past(pc[22:1]), 1'b0})
      else $error("fetch address wrong");
   AST_DMEM: assert property (op_sel == 2'h0 && data_rd && !effective_address[15] |=> dmem_rd_ff &&
      !prog_rd_ff && dmem_addr_ff == $past(effective_address)) else $error("data access misrouted");
   // Main scenarios reached
   cover property (op_sel == 2'h2 ##2 rvalid_ff);
   cover property (rmp && data_rd ##1 prog_rd_ff);
   cover property (op_sel == 2'h1);
endmodule // pgm_map_chk
bind pgm_space_mapper pgm_map_chk i_chk (.clock, .nrst, .data_rd, .data_wr, .op_sel, .effective_address, .wdata,
   .pc, .table_page_reg, .visibility_page_reg, .prog_rd_ff, .prog_wr_ff, .cfg_space_ff, .dmem_rd_ff, .dmem_wr_ff,
   .rvalid_ff, .prog_addr_ff, .prog_wdata_ff, .dmem_addr_ff);

// [tb/pgm_space_mapper_tb.sv]
// Self-checking bench for the program-space mapper.
// Flash model on the far side; inputs change at falling edges.
`timescale 1ns/1ps
module pgm_space_mapper_tb;
   reg         clock = 0, nrst = 0, tpw = 0, vpw = 0, rd = 0, wr = 0, bm = 0, hb = 0;
   reg  [7:0]  pw = 8'h00;
   reg  [1:0]  op = 2'h0;
   reg  [15:0] ea = 16'h0000, wd = 16'h0000;
   reg  [23:1] pc = 23'h000000;
   wire [23:0] fd, pa;
   wire [15:0] pwd, da, rdat;
   wire [7:0]  tp, vp;
   wire [2:0]  be;
   wire        prd, pwr, cfg, drd, dwr, rv;
   integer     num_errors = 0, n_checks = 0;
   always #20 clock = ~clock;
   pgm_space_mapper i_dut (.clock(clock), .nrst(nrst), .table_page_we(tpw), .visibility_page_we(vpw),
      .page_wdata(pw), .op_sel(op), .data_rd(rd), .data_wr(wr), .byte_mode(bm), .high_byte(hb),
      .effective_address(ea), .wdata(wd), .pc(pc), .flash_rdata(fd), .prog_addr_ff(pa), .prog_rd_ff(prd),
      .prog_wr_ff(pwr), .cfg_space_ff(cfg), .prog_wdata_ff(pwd), .prog_byte_en_ff(be), .dmem_addr_ff(da),
      .dmem_rd_ff(drd), .dmem_wr_ff(dwr), .rdata_ff(rdat), .rvalid_ff(rv), .table_page_reg(tp),
      .visibility_page_reg(vp));
   flash_model i_flash (.prog_rd_ff(prd), .prog_addr_ff(pa), .flash_rdata(fd));
   ////////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task chk(input [63:0] nm, input [23:0] e, input [23:0] g);
   begin
      n_checks = n_checks + 1;
      if (e !== g)
      begin
         num_errors = num_errors + 1;
         $display("unexpected %0s exp %h got %h", nm, e, g);
      end
   end
   endtask
   // One-cycle page write, table page when t is set
   task page(input t, input [7:0] v);
   begin
      @(negedge clock);
      {tpw, vpw, pw} = {t, !t, v};
      @(negedge clock);
      {tpw, vpw} = 2'b00;
   end
   endtask
   // One-cycle request; returns with its outputs settled
   task req(input [1:0] s, input r, input w, input b, input h, input [15:0] a);
   begin
      @(negedge clock);
      {op, rd, wr, bm, hb, ea, wd} = {s, r, w, b, h, a, ~a};
      @(negedge clock);
      {op, rd, wr} = 4'h0;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_table(input [7:0] p);
   reg [23:0] f;
   begin
      page(1, p);
      f = {p, 16'hFFFE};
      req(2'h2, 0, 0, 0, 0, 16'hFFFE);
      chk("taddr", f, pa);
      chk("cfg", {23'h0, p[7]}, {23'h0, cfg});
      chk("tpage", {16'h0, p}, {16'h0, tp});
      @(negedge clock);
      chk("tword", {8'h0, f[15:0] ^ 16'hA5C3}, {8'h0, rdat});
      chk("tvalid", 24'h1, {23'h0, rv});
      f = {p, 16'h0001} ^ 24'h3CA5C3;
      req(2'h2, 0, 0, 1, 1, 16'h0001);
      chk("tben", 24'h4, {21'h0, be});
      @(negedge clock);
      chk("tbyte", {16'h0, f[23:16]}, {8'h0, rdat});
      req(2'h2, 0, 0, 1, 0, 16'h0001);
      @(negedge clock);
      chk("tmid", 24'h0000A5, {8'h0, rdat});
      req(2'h2, 0, 0, 1, 0, 16'h0000);
      @(negedge clock);
      chk("tlow", 24'h0000C3, {8'h0, rdat});
      req(2'h3, 0, 0, 0, 0, 16'h0010);
      chk("twrite", {1'b1, 3'h3, 4'h0, 16'hFFEF}, {pwr, be, 4'h0, pwd});
      $display("table page %h done", p);
   end
   endtask
   task t_remap;
   begin
      page(0, 8'hFE);
      req(2'h0, 1, 0, 0, 0, 16'hFFFF);
      chk("vpage", 24'h0000FE, {16'h0, vp});
      chk("raddr", 24'h7F7FFF, pa);
      @(negedge clock);
      chk("rword", {8'h0, 16'hDA3C}, {8'h0, rdat});
      req(2'h0, 0, 1, 0, 0, 16'h8000);
      chk("rwrite", 24'h0, {22'h0, pwr, dwr});
      $display("remap done");
   end
   endtask
   task t_fetch_dmem;
   begin
      pc = 23'h7FFFFF;
      req(2'h1, 0, 0, 0, 0, 16'h0000);
      chk("faddr", 24'h7FFFFE, pa);
      req(2'h0, 1, 0, 0, 0, 16'h7FFF);
      chk("daddr", {8'h2, 16'h7FFF}, {6'h0, drd, prd, da});
      $display("fetch and data done");
   end
   endtask
   task end_sim;
   begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   // Reset, then the scenarios
   initial
   begin
      repeat (5) @(negedge clock);
      nrst = 1;
      chk("rst", 24'h0, pa);
      t_table(8'h00);
      t_table(8'h81);
      t_remap;
      t_fetch_dmem;
      end_sim;
   end
endmodule // pgm_space_mapper_tb
